/* File: src/tmb_timer_bank.sv */
// bank of 256 on-delay, accumulating and off-delay program timers
//
// What this block does
// RL1 - gate on: count up, bit when count >= preset
// RL2 - on_delay gate off clears count and bit
// RL3 - accumulating_delay gate off holds count and bit
// RL4 - on-delay counts saturate at 32767
// RL5 - off_delay gate on: bit on, count zero
// RL6 - off_delay counts only after falling gate
// RL7 - off_delay at preset: bit off, count frozen
// RL8 - gate back early: bit stays, restart zero
// RL9 - inactive step region: off_delay zeroed, idle
// RL10 - reset command clears bit and count
// RL11 - after reset off_delay needs fresh falling gate
// RL12 - first scan clears bits, retained accumulators kept
// RL13 - count unit is the timer time base
// RL14 - accumulating_delay indices and time bases fixed
// RL15 - on_delay/off_delay indices and time bases fixed
// RL16 - index 0..255, preset signed 16 bits
// RL17 - program never shares on/off index
// RL18 - 1 ms timers update on every tick except one in the cycle of their execution, reset command or first scan
// RL19 - 10 ms timers update at scan start
// RL20 - 100 ms timers update when executed
// RL21 - program adds one to preset for margin
// RL22 - 10/100 ms ticks divided from 1 ms tick
`timescale 1ns/1ps
module tmb_timer_bank #(
   parameter int CYC_PER_MS = tmb_pkg::TB_1MS_CYC
) (
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // user program
   input  wire logic                  exec_i,
   input  wire tmb_pkg::tmb_exec_type exec_req_i,
   input  wire logic                  clr_i,
   input  wire logic [7:0]            clr_idx_i,
   input  wire logic                  scan_start_i,
   input  wire logic                  first_scan_i,
   output logic                       res_bit_o,
   output logic [15:0]                res_cnt_o,
   output logic [255:0]               timer_bits_o,
   // register port
   input  wire logic [7:0]            reg_addr_i,
   input  wire logic [31:0]           reg_wdata_i,
   input  wire logic                  reg_wr_i,
   input  wire logic                  reg_rd_i,
   output logic [31:0]                reg_rdata_o
);
   import tmb_pkg::*;

   default clocking cb_dut @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   // ------------------------------------------------------------
   // time base ticks
   // ------------------------------------------------------------
   logic [31:0] div1_q;
   logic [3:0]  div10_q;
   logic [3:0]  div100_q;
   logic        tick1;
   logic        tick10;
   logic        tick100;
   logic [15:0] now100_q;
   logic [15:0] pend10_q;

   assign tick1   = (div1_q == 32'(CYC_PER_MS - 1));
   assign tick10  = tick1 && (div10_q == 4'(TB_DIV_STEP - 1));
   assign tick100 = tick10 && (div100_q == 4'(TB_DIV_STEP - 1));

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         div1_q <= 32'h0000_0000;
      end else if (tick1) begin
         div1_q <= 32'h0000_0000;
      end else begin
         div1_q <= div1_q + 32'h0000_0001;
      end
   end

   // slower bases divided from the 1 ms tick, so all stay aligned
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         div10_q  <= 4'h0;
         div100_q <= 4'h0;
      end else begin
         if (tick1) begin //RL22
            div10_q <= tick10 ? 4'h0 : div10_q + 4'h1;
         end
         if (tick10) begin //RL22
            div100_q <= tick100 ? 4'h0 : div100_q + 4'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         now100_q <= 16'h0000;
      end else if (tick100) begin
         now100_q <= now100_q + 16'h0001;
      end
   end

   // 10 ms intervals gathered during a scan, handed over at the next scan start
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pend10_q <= 16'h0000;
      end else if (scan_start_i) begin //RL19
         pend10_q <= {15'h0000, tick10};
      end else if (tick10 && pend10_q != 16'hffff) begin
         pend10_q <= pend10_q + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   logic [7:0]  sel_q;
   logic [31:0] ctrl_q;
   logic        retain;

   assign retain = ctrl_q[CTRL_RETAIN_B];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sel_q  <= 8'h00;
         ctrl_q <= CTRL_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == REG_SEL) begin
            sel_q <= reg_wdata_i[7:0];
         end
         if (reg_addr_i == REG_CTRL) begin
            ctrl_q <= {31'h0000_0000, reg_wdata_i[CTRL_RETAIN_B]};
         end
      end
   end

   // ------------------------------------------------------------
   // timer type, time base and one update step
   // ------------------------------------------------------------
   function automatic logic tmb_is_accum(input int i);
      return (i < 32) || (i >= 64 && i < 96); //RL14
   endfunction

   function automatic tmb_base_type tmb_base(input int i);
      int j;
      j = i % 32;
      if (i > 100) return TB_100MS; //RL15
      if (j == 0) return TB_1MS;
      if (j <= 4) return TB_10MS;
      return TB_100MS;
   endfunction

   // pend_gate is the gate now, gate the one seen at the last step
   function automatic tmb_state_type tmb_step(input tmb_state_type s,
                                              input logic          accum,
                                              input logic [15:0]   dt);
      tmb_state_type n;
      logic [16:0]   sum;
      logic [16:0]   pre;
      n   = s;
      sum = {1'b0, s.cnt} + {1'b0, dt};
      pre = {s.preset[15], s.preset};
      if (s.off_delay && !accum) begin
         if (!s.region_on) begin //RL9
            n.cnt  = 16'h0000;
            n.tbit = 1'b0;
            n.run  = 1'b0;
         end else if (s.pend_gate) begin //RL5 RL8
            n.cnt  = 16'h0000;
            n.tbit = 1'b1;
            n.run  = 1'b0;
         end else if (s.gate) begin //RL6
            n.run  = 1'b1;
         end else if (s.run) begin
            if ($signed(sum) >= $signed(pre)) begin //RL7
               n.cnt  = s.preset[15] ? 16'h0000 : s.preset;
               n.tbit = 1'b0;
               n.run  = 1'b0;
            end else begin
               n.cnt  = sum[15:0];
            end
         end
      end else if (s.pend_gate) begin //RL1
         n.cnt  = (sum > {1'b0, CNT_MAX}) ? CNT_MAX : sum[15:0]; //RL4
         n.tbit = $signed({1'b0, n.cnt}) >= $signed(pre);
      end else if (!accum) begin //RL2
         n.cnt  = 16'h0000;
         n.tbit = 1'b0;
      end
      // accumulating timers keep count and bit with the gate off, RL3
      n.gate = s.pend_gate; //RL3
      return n;
   endfunction

   // ------------------------------------------------------------
   // timer array
   // ------------------------------------------------------------
   tmb_state_type st [TMB_COUNT];

   for (genvar i = 0; i < TMB_COUNT; i++) begin : g_tmr
      localparam logic         ACCUM = tmb_is_accum(i); //RL14 RL15
      localparam tmb_base_type BASE  = tmb_base(i);     //RL13
      tmb_state_type s_q;
      tmb_state_type lat;
      logic          hit;

      assign hit = exec_i && (exec_req_i.idx == 8'(i)); //RL16

      always_comb begin
         lat           = s_q;
         lat.pend_gate = exec_req_i.gate;
         lat.preset    = exec_req_i.preset;
         lat.off_delay = exec_req_i.off_delay;
         lat.region_on = exec_req_i.region_on;
      end

      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            s_q <= '0;
         end else if (clr_i && clr_idx_i == 8'(i)) begin
            s_q.cnt       <= 16'h0000; //RL10
            s_q.tbit      <= 1'b0;
            s_q.run       <= 1'b0;
            // forget the gate so only a fresh fall restarts
            s_q.gate      <= 1'b0; //RL11
            s_q.pend_gate <= 1'b0;
         end else if (first_scan_i) begin
            s_q.tbit <= 1'b0; //RL12
            s_q.run  <= 1'b0;
            if (!(ACCUM && retain)) begin
               s_q.cnt <= 16'h0000;
            end
         end else if (hit) begin
            unique case (BASE)
               TB_1MS:  s_q <= tmb_step(lat, ACCUM, 16'h0000);
               // 10 ms timers only latch here, the step waits for
               // the next scan start so the scan sees constant values
               TB_10MS: s_q <= lat;
               TB_100MS: begin
                  s_q       <= tmb_step(lat, ACCUM,
                                        now100_q - s_q.stamp); //RL20
                  s_q.stamp <= now100_q;
               end
            endcase
         end else if (BASE == TB_1MS && tick1) begin
            s_q <= tmb_step(s_q, ACCUM, 16'h0001); //RL18
         end else if (BASE == TB_10MS && scan_start_i) begin
            s_q <= tmb_step(s_q, ACCUM, pend10_q); //RL19
         end
      end

      assign st[i]           = s_q;
      assign timer_bits_o[i] = s_q.tbit;
   end

   // ------------------------------------------------------------
   // result of the executed operation, one cycle later
   // ------------------------------------------------------------
   tmb_state_type sel_st;
   logic          ex_q;
   logic [7:0]    ex_idx_q;

   assign sel_st    = st[exec_req_i.idx];
   assign res_bit_o = st[ex_idx_q].tbit;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ex_q     <= 1'b0;
         ex_idx_q <= 8'h00;
      end else begin
         ex_q <= exec_i;
         if (exec_i) begin
            ex_idx_q <= exec_req_i.idx;
         end
      end
   end

   always_comb begin
      res_cnt_o = st[ex_idx_q].cnt;
   end

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   tmb_state_type rd_st;
   assign rd_st = st[sel_q];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0000_0000;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            REG_SEL:   reg_rdata_o <= {24'h000000, sel_q};
            REG_COUNT: reg_rdata_o <= {16'h0000, rd_st.cnt};
            REG_STAT:  reg_rdata_o <= {27'h0000000, rd_st.off_delay,
                                       rd_st.run, rd_st.gate,
                                       rd_st.region_on, rd_st.tbit};
            REG_CTRL:  reg_rdata_o <= ctrl_q;
            default:   reg_rdata_o <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata_o <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   logic ex100;
   logic ex_nr;
   logic clean;

   assign ex100 = exec_i && tmb_base(int'(exec_req_i.idx)) == TB_100MS;
   assign ex_nr = !tmb_is_accum(int'(exec_req_i.idx));
   assign clean = !first_scan_i && !(clr_i && clr_idx_i == exec_req_i.idx);

   sequence s_off_exec;
      ex100 && clean && ex_nr && exec_req_i.off_delay;
   endsequence

   a_on_bit_preset: assert property ( //RL1
      ex100 && clean && exec_req_i.gate && !(ex_nr && exec_req_i.off_delay)
      |=> res_bit_o == ($signed({1'b0, res_cnt_o})
                        >= $signed({$past(exec_req_i.preset[15]),
                                    $past(exec_req_i.preset)})))
      else $error("timer bit disagrees with count and preset");

   a_on_gate_off: assert property ( //RL2
      ex100 && clean && ex_nr && !exec_req_i.off_delay && !exec_req_i.gate
      |=> res_cnt_o == 16'h0000 && !res_bit_o)
      else $error("on_delay not cleared on gate off");

   a_accum_hold: assert property ( //RL3
      ex100 && clean && !ex_nr && !exec_req_i.gate
      |=> res_cnt_o == $past(sel_st.cnt) && res_bit_o == $past(sel_st.tbit))
      else $error("accumulating_delay lost its state");

   a_count_sat: assert property ( //RL4
      ex_q |-> !res_cnt_o[15])
      else $error("count passed 32767");

   a_off_gate_on: assert property ( //RL5
      s_off_exec ##0 (exec_req_i.gate && exec_req_i.region_on)
      |=> res_bit_o && res_cnt_o == 16'h0000)
      else $error("off_delay not set by gate on");

   a_off_no_count: assert property ( //RL6
      s_off_exec ##0 (exec_req_i.region_on && !exec_req_i.gate
                      && !sel_st.gate && !sel_st.run)
      |=> res_cnt_o == $past(sel_st.cnt))
      else $error("off_delay counted without a falling gate");

   a_off_freeze: assert property ( //RL7
      s_off_exec ##0 (exec_req_i.region_on && !exec_req_i.preset[15])
      |=> res_cnt_o <= $past(exec_req_i.preset))
      else $error("off_delay count beyond preset");

   a_region_off: assert property ( //RL9
      s_off_exec ##0 !exec_req_i.region_on
      |=> res_cnt_o == 16'h0000 && !res_bit_o)
      else $error("off_delay active in idle region");

   a_reset_cmd: assert property ( //RL10
      clr_i |=> !timer_bits_o[$past(clr_idx_i)]
                && st[$past(clr_idx_i)].cnt == 16'h0000)
      else $error("reset command left timer state");

   a_tick_align: assert property ( //RL22
      tick10 |-> tick1 ##1 !tick1)
      else $error("10 ms tick off the 1 ms grid");

endmodule

/* File: src/tmb_pkg.sv */
// shared constants and types of the timer bank
package tmb_pkg;

   // ------------------------------------------------------------
   // sizes and timing
   // ------------------------------------------------------------
   localparam int          TMB_COUNT      = 256;
   localparam int          TMB_IDX_W      = 8;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          TB_1MS_NS      = 1_000_000;
   localparam int          TB_1MS_CYC     = TB_1MS_NS / CLK_PERIOD_NS;
   localparam int          TB_DIV_STEP    = 10;
   localparam logic [15:0] CNT_MAX        = 16'h7fff;

   // ------------------------------------------------------------
   // register offsets and reset values
   // ------------------------------------------------------------
   localparam logic [7:0]  REG_SEL        = 8'h00;
   localparam logic [7:0]  REG_COUNT      = 8'h04;
   localparam logic [7:0]  REG_STAT       = 8'h08;
   localparam logic [7:0]  REG_CTRL       = 8'h0c;
   localparam int          CTRL_RETAIN_B  = 0;
   localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

   typedef enum logic [1:0] {TB_1MS, TB_10MS, TB_100MS} tmb_base_type;

   // one timer operation from the user program
   typedef struct packed {
      logic [TMB_IDX_W-1:0] idx;
      logic                 gate;
      logic [15:0]          preset;
      logic                 off_delay;
      logic                 region_on;
   } tmb_exec_type;

   typedef struct packed {
      logic [15:0] cnt;
      logic        tbit;
      logic        gate;
      logic        pend_gate;
      logic        run;
      logic        off_delay;
      logic        region_on;
      logic [15:0] preset;
      logic [15:0] stamp;
   } tmb_state_type;

endpackage

/* File: verif/test_tmb_timer_bank.sv */
// self-checking bench for the program timer bank
`timescale 1ns/1ps
module test_tmb_timer_bank;
   import tmb_pkg::*;
   // ------------------------------------------------------------
   // signals and design
   // ------------------------------------------------------------
   localparam int CPM = 10;
   logic         clk_i        = 1'b0;
   logic         rst_n_i      = 1'b0;
   logic         exec_i       = 1'b0;
   tmb_exec_type exec_req_i   = '0;
   logic         clr_i        = 1'b0;
   logic [7:0]   clr_idx_i    = 8'h00;
   logic         scan_start_i = 1'b0;
   logic         first_scan_i = 1'b0;
   logic         res_bit_o;
   logic [15:0]  res_cnt_o;
   logic [255:0] timer_bits_o;
   logic [7:0]   reg_addr_i   = 8'h00;
   logic [31:0]  reg_wdata_i  = 32'h0000_0000;
   logic         reg_wr_i     = 1'b0;
   logic         reg_rd_i     = 1'b0;
   logic [31:0]  reg_rdata_o;
   int           err_total    = 0;
   int           total_checks = 0;
   logic [15:0]  c0;
   logic [31:0]  rv;

   always #5 clk_i = ~clk_i;

   tmb_timer_bank #(.CYC_PER_MS(CPM)) i_dut (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n_i),
      .exec_i       (exec_i),
      .exec_req_i   (exec_req_i),
      .clr_i        (clr_i),
      .clr_idx_i    (clr_idx_i),
      .scan_start_i (scan_start_i),
      .first_scan_i (first_scan_i),
      .res_bit_o    (res_bit_o),
      .res_cnt_o    (res_cnt_o),
      .timer_bits_o (timer_bits_o),
      .reg_addr_i   (reg_addr_i),
      .reg_wdata_i  (reg_wdata_i),
      .reg_wr_i     (reg_wr_i),
      .reg_rd_i     (reg_rd_i),
      .reg_rdata_o  (reg_rdata_o)
   );

   // ------------------------------------------------------------
   // drivers and compare
   // ------------------------------------------------------------
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // one timer operation after w+1 idle cycles
   task automatic run(input logic [7:0] i, input logic g,
                      input logic [15:0] p, input logic od,
                      input logic rg, input int w);
      cyc(w);
      @(posedge clk_i);
      exec_i     <= 1'b1;
      exec_req_i <= {i, g, p, od, rg};
      @(posedge clk_i);
      exec_i <= 1'b0;
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   task automatic cnt_of(input logic [7:0] i, output logic [31:0] d);
      wr(REG_SEL, {24'h000000, i});
      rd(REG_COUNT, d);
   endtask

   // kind: 0 scan start, 1 first scan, 2 reset command
   task automatic pulse(input int kind, input logic [7:0] i);
      @(posedge clk_i);
      if (kind == 0) scan_start_i <= 1'b1;
      if (kind == 1) first_scan_i <= 1'b1;
      if (kind == 2) clr_i <= 1'b1;
      clr_idx_i <= i;
      @(posedge clk_i);
      scan_start_i <= 1'b0;
      first_scan_i <= 1'b0;
      clr_i        <= 1'b0;
      #1;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      rd(REG_SEL, rv);
      chk("sel reset", 32'h0000_0000, rv);
      rd(REG_CTRL, rv);
      chk("ctrl reset", CTRL_RST, rv);
      rd(8'h40, rv);
      chk("unmapped read", 32'h0000_0000, rv);
      @(posedge clk_i);
      #1 chk("rdata idle", 32'h0000_0000, reg_rdata_o);
      wr(REG_SEL, 32'h0000_00a5);
      wr(8'h10, 32'hffff_ffff);
      rd(REG_SEL, rv);
      chk("sel readback", 32'h0000_00a5, rv);
      $display("done t_regs");
   endtask

   task automatic t_bases;
      logic [7:0] ix [10] = '{8'h00, 8'h40, 8'h20, 8'h60, 8'h01,
                              8'h1f, 8'h3f, 8'h61, 8'h65, 8'hff};
      for (int k = 0; k < 10; k++) begin
         run(ix[k], 1'b1, 16'h7fff, 1'b0, 1'b1, 0);
         c0 = res_cnt_o;
         cyc(50);
         chk("live count", c0 + ((k < 4) ? 5 : 0), res_cnt_o);
         if (k < 4) begin
            run(ix[k], 1'b0, 16'h7fff, 1'b0, 1'b1, 0);
            c0 = res_cnt_o;
            chk("gate off kept", (k < 2) ? 1 : 0, c0 != 0);
            cyc(30);
            chk("gate off count", (k < 2) ? c0 : 0, res_cnt_o);
         end
      end
      $display("done t_bases");
   endtask

   task automatic t_scan;
      run(8'h21, 1'b1, 16'h0002, 1'b0, 1'b1, 0);
      pulse(0, 8'h00);
      c0 = res_cnt_o;
      cyc(298);
      chk("scan hold", c0, res_cnt_o);
      pulse(0, 8'h00);
      chk("scan add", c0 + 3, res_cnt_o);
      chk("scan bit", 1, res_bit_o);
      $display("done t_scan");
   endtask

   task automatic t_on;
      run(8'h28, 1'b0, 16'h0003, 1'b0, 1'b1, 0);
      for (int k = 1; k < 5; k++) begin
         run(8'h28, 1'b1, 16'h0003, 1'b0, 1'b1, 998);
         chk("on count", k, res_cnt_o);
         chk("on bit", k >= 3, res_bit_o);
      end
      run(8'h28, 1'b0, 16'h0003, 1'b0, 1'b1, 998);
      chk("on clear count", 0, res_cnt_o);
      chk("on clear bit", 0, timer_bits_o[40]);
      run(8'h28, 1'b1, 16'hfffb, 1'b0, 1'b1, 998);
      chk("negative preset", 1, res_bit_o);
      $display("done t_on");
   endtask

   task automatic t_accum;
      run(8'h05, 1'b0, 16'h0002, 1'b0, 1'b1, 0);
      for (int k = 1; k < 3; k++) begin
         run(8'h05, 1'b1, 16'h0002, 1'b0, 1'b1, 998);
         chk("acc count", k, res_cnt_o);
         chk("acc bit", k >= 2, res_bit_o);
      end
      run(8'h05, 1'b0, 16'h0002, 1'b0, 1'b1, 998);
      chk("acc hold count", 2, res_cnt_o);
      chk("acc hold bit", 1, res_bit_o);
      $display("done t_accum");
   endtask

   task automatic t_off;
      for (int k = 0; k < 3; k++) begin
         run(8'h33, 1'b0, 16'h0003, 1'b1, 1'b1, 998);
         chk("low no count", 0, {res_bit_o, res_cnt_o});
      end
      run(8'h32, 1'b1, 16'h0003, 1'b1, 1'b1, 0);
      chk("off on", 32'h0001_0000, {res_bit_o, res_cnt_o});
      for (int k = 0; k < 7; k++) begin
         run(8'h32, 1'b0, 16'h0003, 1'b1, 1'b1, 998);
         chk("off bit", res_cnt_o != 3, res_bit_o);
      end
      chk("off frozen", 3, res_cnt_o);
      chk("off vector", 0, timer_bits_o[50]);
      run(8'h32, 1'b1, 16'h0003, 1'b1, 1'b1, 998);
      for (int k = 0; k < 3; k++) begin
         run(8'h32, k == 2, 16'h0003, 1'b1, 1'b1, 998);
         chk("early bit", 1, res_bit_o);
      end
      chk("early count", 0, res_cnt_o);
      run(8'h32, 1'b1, 16'h0003, 1'b1, 1'b0, 998);
      chk("region off", 0, {res_bit_o, res_cnt_o});
      wr(REG_SEL, 32'h0000_0032);
      rd(REG_STAT, rv);
      chk("stat region off", 32'h0000_0014, rv);
      $display("done t_off");
   endtask

   task automatic t_clear;
      pulse(2, 8'h40);
      cnt_of(8'h40, rv);
      chk("clr acc", 0, {timer_bits_o[64], rv[15:0]});
      run(8'h32, 1'b1, 16'h0003, 1'b1, 1'b1, 998);
      pulse(2, 8'h32);
      chk("clr off bit", 0, timer_bits_o[50]);
      for (int k = 0; k < 3; k++) begin
         run(8'h32, 1'b0, 16'h0003, 1'b1, 1'b1, 998);
         chk("clr no restart", 0, {res_bit_o, res_cnt_o});
      end
      $display("done t_clear");
   endtask

   task automatic t_first;
      run(8'h21, 1'b1, 16'h0002, 1'b0, 1'b1, 0);
      wr(REG_CTRL, 32'h0000_0001);
      rd(REG_CTRL, rv);
      chk("ctrl readback", 32'h0000_0001, rv);
      pulse(1, 8'h00);
      chk("first bits", 0, |timer_bits_o);
      cnt_of(8'h05, rv);
      chk("retained acc", 2, rv);
      cnt_of(8'h21, rv);
      chk("first on count", 0, rv);
      wr(REG_CTRL, 32'h0000_0000);
      pulse(1, 8'h00);
      cnt_of(8'h05, rv);
      chk("unretained acc", 0, rv);
      $display("done t_first");
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      cyc(90000);
      err_total++;
      $display("[FAIL] watchdog expected done seen hang");
      summarize();
   end

   initial begin
      cyc(8);
      rst_n_i <= 1'b1;
      t_regs();
      t_bases();
      t_scan();
      t_on();
      t_accum();
      t_off();
      t_clear();
      t_first();
      summarize();
   end
endmodule
